// *** rtl/gpm_pin_mux.sv ***
// Pin multiplexer top: GPIO bank, clock outputs, strap capture, host/PCI pins.
// Assumes pins arrive as separate in/out/oe_n signals and are sampled on clk_in.
//
// The register addresses and strobed register access were decided locally.
`default_nettype none

module gpm_pin_mux #(
  parameter int GPIO_W = 16  // GPIO count, fixed by pin map
) (
  input wire logic clk_in,                        // 250 MHz clock
  input wire logic nrst_in,                       // Synchronous reset, active low
  input wire logic [3:0] reg_addr_in,             // Register word address
  input wire logic [31:0] reg_wdata_in,           // Register write data
  input wire logic reg_wr_in,                     // Write strobe
  input wire logic reg_rd_in,                     // Read strobe
  output logic [31:0] reg_rdata_out,              // Read data, cycle after strobe
  output logic irq_out,                           // Level interrupt
  input wire logic pci_enable_strap_in,           // PCI strap, high = PCI
  input wire logic serial2_enable_strap_in,       // Serial-2 strap
  input wire logic [GPIO_W-1:0] gpio_in,          // GPIO pin levels
  output logic [GPIO_W-1:0] gpio_out,             // GPIO pin drive values
  output logic [GPIO_W-1:0] gpio_oe_n_out,        // GPIO enables, low drives
  output logic serial2_ext_clock_in_out,          // Pin 8 clock to serial port 2
  output logic gpio_interrupt_out,                // Internal copy of pin-0 interrupt
  output logic [3:0] ext_irq_out,                 // Polarity-corrected ext interrupts
  output logic [6:0] pci_side_in_out,             // PCI inputs: rst,clk,gnt,idsel,cbe3
  input wire logic pci_interrupt_a_in,            // PCI core interrupt A request
  input wire logic pci_request_in,                // PCI core bus request
  input wire logic pci_cbe3_o_in,                 // PCI core byte enable 3 drive
  input wire logic pci_cbe3_oe_n_in,              // PCI core byte enable 3 enable
  input wire logic host_irq_in,                   // Host port interrupt request
  output logic host_irq_out,                      // Shared pin: host irq / frame out
  output logic host_irq_oe_n_out,                 // Its enable, low drives
  input wire logic pci_frame_o_in,                // PCI core frame drive
  input wire logic pci_frame_oe_n_in,             // PCI core frame enable
  input wire logic [3:0] host_ctl_pin_in,         // sel_hi, sel_lo, halfword, rw pins
  output logic [3:0] host_ctl_out,                // Those pins in host mode (halfword only when narrow), else 0
  output logic [3:0] pci_ctl_out,                 // devsel, stop, trdy, cbe2 in PCI
  input wire logic [gpm_pkg::HDATA_W-1:0] host_data_pin_in,  // Shared data pin levels
  input wire logic [gpm_pkg::HDATA_W-1:0] host_data_o_in,    // Data to drive from core
  input wire logic host_data_drive_in,                       // Core wants to drive data
  output logic [gpm_pkg::HDATA_W-1:0] host_data_out,         // Shared data drive values
  output logic [gpm_pkg::HDATA_W-1:0] host_data_oe_n_out,    // Enables, low drives
  output logic host_port_narrow_out,              // Host bus 16 bits
  output logic host_port_wide_out,                // Host bus 32 bits
  output logic pci_mode_out                       // PCI selected
);
  localparam int HDATA_W = gpm_pkg::HDATA_W;

  // Only the sixteen-pin map is wired up below
  if (GPIO_W != 16) begin : g_bad_width
    $error("GPIO_W must be 16");
  end

  // ==========================================================
  // Registers
  // ==========================================================
  logic [31:0] func;
  logic [GPIO_W-1:0] dir;
  logic [GPIO_W-1:0] dout;
  logic [3:0] ext_irq_polarity_field;
  logic [gpm_pkg::ST_W-1:0] stat;
  logic [gpm_pkg::ST_W-1:0] mask;
  gpm_pkg::gpm_strap_type strap;
  logic [GPIO_W-1:0] gin_q;
  logic [2:0] div6_cnt;
  logic [1:0] div4_cnt;
  logic clk6;
  logic clk4;

  // Register decode
  wire wr_func = reg_wr_in && (reg_addr_in == gpm_pkg::OFS_FUNC);
  wire wr_dir = reg_wr_in && (reg_addr_in == gpm_pkg::OFS_DIR);
  wire wr_out = reg_wr_in && (reg_addr_in == gpm_pkg::OFS_OUT);
  wire wr_pol = reg_wr_in && (reg_addr_in == gpm_pkg::OFS_POL);
  wire wr_stat = reg_wr_in && (reg_addr_in == gpm_pkg::OFS_STAT);
  wire wr_mask = reg_wr_in && (reg_addr_in == gpm_pkg::OFS_MASK);

  // Strap capture: held in reset and frozen after release
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      strap.pci_mode <= pci_enable_strap_in;
      strap.serial2_en <= serial2_enable_strap_in;
      strap.host_port_wide <= host_data_pin_in[gpm_pkg::WIDTH_STRAP_BIT];
    end
  end

  // Control registers
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      func <= gpm_pkg::FUNC_RST;
      dir <= '0;
      dout <= '0;
      ext_irq_polarity_field <= 4'h0;
      mask <= '0;
    end else begin
      if (wr_func) func <= reg_wdata_in;
      if (wr_dir) dir <= reg_wdata_in[GPIO_W-1:0];
      if (wr_out) dout <= reg_wdata_in[GPIO_W-1:0];
      if (wr_pol) ext_irq_polarity_field <= reg_wdata_in[3:0];
      if (wr_mask) mask <= reg_wdata_in[gpm_pkg::ST_W-1:0];
    end
  end

  // ==========================================================
  // Edge events and interrupt
  // ==========================================================
  // Polarity bit high means falling edge is active
  wire [3:0] ext_now = gpio_in[gpm_pkg::EXT_BASE +: gpm_pkg::NUM_EXT];
  wire [3:0] ext_old = gin_q[gpm_pkg::EXT_BASE +: gpm_pkg::NUM_EXT];
  wire [3:0] ext_lvl = ext_now ^ ext_irq_polarity_field;
  wire [3:0] ext_oldl = ext_old ^ ext_irq_polarity_field;
  wire [3:0] ext_edge = ext_lvl & ~ext_oldl;
  wire gp0_edge = gpio_in[0] & ~gin_q[0];
  wire [gpm_pkg::ST_W-1:0] ev = {gp0_edge, ext_edge};
  // Set wins over a write-one clear in the same cycle
  wire [gpm_pkg::ST_W-1:0] next_stat =
    (stat & ~(wr_stat ? reg_wdata_in[gpm_pkg::ST_W-1:0] : '0)) | ev;

  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      // Load the live levels so pulled-up pins give no false edge after reset
      gin_q <= gpio_in;
      stat <= '0;
    end else begin
      gin_q <= gpio_in;
      stat <= next_stat;
    end
  end

  assign irq_out = |(stat & mask);
  assign ext_irq_out = ext_lvl;

  // ==========================================================
  // Clock dividers, enable-style counters on the one clock
  // ==========================================================
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      div6_cnt <= '0;
      div4_cnt <= '0;
      clk6 <= 1'b0;
      clk4 <= 1'b0;
    end else begin
      div6_cnt <= (div6_cnt == 3'(gpm_pkg::DIV6 - 1)) ? 3'h0 : div6_cnt + 3'h1;
      div4_cnt <= div4_cnt + 2'h1;
      clk6 <= (div6_cnt < 3'(gpm_pkg::DIV6 / 2)) ? 1'b0 : 1'b1;
      clk4 <= div4_cnt[1];
    end
  end

  // ==========================================================
  // GPIO pin muxing
  // ==========================================================
  wire hi_en = func[gpm_pkg::FN_HI_EN];
  wire pci = strap.pci_mode;
  logic [GPIO_W-1:0] next_o;
  logic [GPIO_W-1:0] next_oen;

  always_comb begin
    next_o = dout;
    next_oen = ~dir;
    // Pins 7..4: plain GPIO with interrupt capture
    // Pin 3: input-only until made bidirectional
    if (!func[gpm_pkg::FN_GP3_BIDIR]) next_oen[3] = 1'b1;
    // Pin 0: input, output-only GPIO or interrupt out
    next_oen[0] = 1'b1;
    if (func[gpm_pkg::FN_GP0_INT]) begin
      next_o[0] = irq_out;
      next_oen[0] = 1'b0;
    end else if (func[gpm_pkg::FN_GP0_OUT]) begin
      next_oen[0] = 1'b0;
    end
    // Pin 1 and 2: clock outputs unless reassigned
    if (!func[gpm_pkg::FN_GP1]) begin
      next_o[1] = clk4;
      next_oen[1] = 1'b0;
    end
    if (!func[gpm_pkg::FN_GP2]) begin
      next_o[2] = clk6;
      next_oen[2] = 1'b0;
    end
    // Pin 8: serial-2 clock input by default
    if (!func[gpm_pkg::FN_GP8]) next_oen[8] = 1'b1;
    // Pins 15..9: idle until enabled, then GPIO or PCI sideband
    if (!hi_en) begin
      next_oen[15:9] = 7'h7f;
    end else if (pci) begin
      next_oen[15:9] = 7'h7f;
      next_o[13] = 1'b0;                                          // Open drain, pulls low only
      next_oen[13] = ~pci_interrupt_a_in;
      next_o[11] = pci_request_in;
      next_oen[11] = 1'b0;
      next_o[10] = pci_cbe3_o_in;
      next_oen[10] = pci_cbe3_oe_n_in;
    end
  end

  // Pin outputs are registered so data outputs come from flip-flops
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      gpio_out <= '0;
      gpio_oe_n_out <= '1;
    end else begin
      gpio_out <= next_o;
      gpio_oe_n_out <= next_oen;
    end
  end

  assign serial2_ext_clock_in_out = func[gpm_pkg::FN_GP8] ? 1'b0 : gpio_in[8];
  assign gpio_interrupt_out = func[gpm_pkg::FN_GP0_INT] & irq_out;
  // rst, clk, gnt, idsel, cbe3 as seen by the PCI core; zero when not PCI
  assign pci_side_in_out = (hi_en && pci) ?
    {gpio_in[15], gpio_in[14], gpio_in[12], gpio_in[9], gpio_in[10], 2'h0} : 7'h00;

  // ==========================================================
  // Host port / PCI shared pins
  // ==========================================================
  wire narrow = !strap.host_port_wide;
  // Host interrupt driven in host mode, frame by PCI core otherwise
  assign host_irq_out = pci ? pci_frame_o_in : host_irq_in;
  assign host_irq_oe_n_out = pci ? pci_frame_oe_n_in : 1'b0;
  // Host drives the control pins; the device only steers them
  assign host_ctl_out = pci ? 4'h0 :
    {host_ctl_pin_in[3:2], host_ctl_pin_in[1] & narrow, host_ctl_pin_in[0]};
  assign pci_ctl_out = pci ? host_ctl_pin_in : 4'h0;

  // Data bus: upper half left undriven in narrow host mode
  genvar gi;
  generate
    for (gi = 0; gi < HDATA_W; gi++) begin : g_hd
      wire used = pci || !narrow || (gi < 16);
      assign host_data_out[gi] = host_data_o_in[gi];
      assign host_data_oe_n_out[gi] = !(host_data_drive_in && used);
    end
  endgenerate

  assign host_port_narrow_out = !pci && narrow;
  assign host_port_wide_out = !pci && !narrow;
  assign pci_mode_out = pci;

  // ==========================================================
  // Register read port
  // ==========================================================
  logic [31:0] rd_mux;
  always_comb begin
    case (reg_addr_in)
      gpm_pkg::OFS_FUNC: rd_mux = func;
      gpm_pkg::OFS_DIR: rd_mux = {16'h0, dir};
      gpm_pkg::OFS_OUT: rd_mux = {16'h0, dout};
      gpm_pkg::OFS_IN: rd_mux = {16'h0, gin_q};
      gpm_pkg::OFS_POL: rd_mux = {28'h0, ext_irq_polarity_field};
      gpm_pkg::OFS_STAT: rd_mux = {27'h0, stat};
      gpm_pkg::OFS_MASK: rd_mux = {27'h0, mask};
      gpm_pkg::OFS_MODE: rd_mux = {29'h0, strap};
      default: rd_mux = 32'h0;
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (!nrst_in) reg_rdata_out <= 32'h0;
    else reg_rdata_out <= reg_rd_in ? rd_mux : 32'h0;
  end

endmodule

`default_nettype wire

// *** rtl/gpm_pkg.sv ***
// Package for the GPIO / host-port / PCI pin multiplexer.
// Assumes one 250 MHz clock and a synchronous active-low reset.
//
// Function
// - Software sets each of four external interrupt edge polarities independently.
// - Pins 15..9 route as bidirectional GPIO or as PCI sideband signals.
// - After reset, pins 15..9 have no active function until one is selected.
// - Pin 3 is input-only after reset; it may be made bidirectional.
// - Pin 0 is an input by default; it may be an output or interrupt out.
// - Pin 8 is the serial-2 clock input by default; it may become GPIO 8.
// - Pin 2 drives the clock divided by six by default; it may become GPIO 2.
// - Pin 1 drives the clock divided by four by default; it may become GPIO 1.
// - The PCI strap picks host port with GPIO 15..9, or PCI, with serial-2 strap.
// - Host mode drives the host interrupt out; PCI mode uses the pin as frame.
// - Host width is caught at reset from data pin 5: low narrow, high wide.
// - With the PCI strap low, the shared data pins are the host data bus.
`default_nettype none

package gpm_pkg;

  // ==========================================================
  // Register map, word offsets on the plain register port
  // ==========================================================
  localparam logic [3:0] OFS_FUNC = 4'h0;     // Pin function select
  localparam logic [3:0] OFS_DIR = 4'h1;      // GPIO direction, 1 = output
  localparam logic [3:0] OFS_OUT = 4'h2;      // GPIO output value
  localparam logic [3:0] OFS_IN = 4'h3;       // GPIO pin levels, read only
  localparam logic [3:0] OFS_POL = 4'h4;      // External interrupt polarity
  localparam logic [3:0] OFS_STAT = 4'h5;     // Sticky event status, write one to clear
  localparam logic [3:0] OFS_MASK = 4'h6;     // Interrupt mask, 1 = enabled
  localparam logic [3:0] OFS_MODE = 4'h7;     // Strap results, read only

  // ==========================================================
  // Function register fields
  // ==========================================================
  localparam int FN_GP0_OUT = 0;     // Pin 0 output-only GPIO
  localparam int FN_GP0_INT = 1;     // Pin 0 carries the GPIO interrupt
  localparam int FN_GP1 = 2;         // Pin 1 as GPIO instead of clock/4
  localparam int FN_GP2 = 3;         // Pin 2 as GPIO instead of clock/6
  localparam int FN_GP3_BIDIR = 4;   // Pin 3 bidirectional
  localparam int FN_GP8 = 5;         // Pin 8 as GPIO instead of serial-2 clock
  localparam int FN_HI_EN = 6;       // Pins 15..9 active function enable
  localparam logic [31:0] FUNC_RST = 32'h0000_0000;

  // Status bits: [3:0] external interrupt edges, [4] pin 0 input edge
  localparam int NUM_EXT = 4;
  localparam int EXT_BASE = 4;       // External interrupts are GPIO 7..4
  localparam int ST_GP0 = 4;
  localparam int ST_W = 5;

  // Clock divider periods
  localparam int DIV4 = 4;
  localparam int DIV6 = 6;
  localparam int HDATA_W = 32;
  localparam int WIDTH_STRAP_BIT = 5;

  // Strap results gathered together
  typedef struct packed {
    logic pci_mode;
    logic serial2_en;
    logic host_port_wide;
  } gpm_strap_type;

  // One pin's drive value and enable; oe_n low while driving
  typedef struct packed {
    logic o;
    logic oe_n;
  } gpm_drive_type;

endpackage

`default_nettype wire

// *** tb/gpm_host_model.sv ***
// Host processor model: control pins, data pins and the width strap resistor.
// Assumes one clock; the host acts one cycle after it is told to.
`default_nettype none
module gpm_host_model (
  input wire logic clk_in,  // Clock
  input wire logic nrst_in,  // Reset
  input wire logic wide_in,  // Strap resistor
  input wire logic drive_in,  // Host drives data
  input wire logic [3:0] ctl_in,  // Select, half-word, direction
  input wire logic [31:0] data_in,  // Host data
  output logic [3:0] ctl_pin_out,  // Control pins
  output logic [31:0] data_pin_out  // Data pins
);
  // A released bus has no keeper, so it shows a moving pattern
  always_ff @(posedge clk_in) begin
    ctl_pin_out <= ctl_in;
    if (!nrst_in) data_pin_out <= {26'h0, wide_in, 5'h00};
    else if (drive_in) data_pin_out <= data_in;
    else data_pin_out <= ~data_pin_out;
  end
endmodule
`default_nettype wire

// *** tb/gpm_pin_mux_properties.sv ***
// Checker for the pin multiplexer: clock shapes, default roles, routing.
// Assumes binding to gpm_pin_mux; sees only its ports.
`default_nettype none
module gpm_pin_mux_properties #(
  parameter int GPIO_W = 16  // As design
) (
  input wire logic clk_in,  // Clock
  input wire logic nrst_in,  // Reset
  input wire logic [3:0] reg_addr_in,  // Address
  input wire logic [31:0] reg_wdata_in,  // Write data
  input wire logic reg_wr_in,  // Write strobe
  input wire logic [GPIO_W-1:0] gpio_in,  // Pin levels
  input wire logic [GPIO_W-1:0] gpio_out,  // Pin drive
  input wire logic [GPIO_W-1:0] gpio_oe_n_out,  // Pin enables
  input wire logic [3:0] ext_irq_out,  // Ext interrupts
  input wire logic [6:0] pci_side_in_out,  // PCI inputs
  input wire logic host_irq_in,  // Host irq request
  input wire logic host_irq_out,  // Shared irq pin
  input wire logic [3:0] host_ctl_pin_in,  // Control pins
  input wire logic [3:0] host_ctl_out,  // Host controls
  input wire logic pci_mode_out,  // PCI mode
  input wire logic host_port_narrow_out,  // 16-bit bus
  input wire logic [31:0] host_data_oe_n_out  // Data enables
);
  // ==========================================================
  // Shadows; age hides the lag from a write to the pins
  // ==========================================================
  logic [6:0] fn;
  logic [3:0] pol, age;
  logic calm;
  logic wr_fn;
  assign wr_fn = reg_wr_in && reg_addr_in == gpm_pkg::OFS_FUNC;
  assign calm = age > 4'h3;
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      fn <= 7'h00;
      pol <= 4'h0;
      age <= 4'h0;
    end else begin
      if (wr_fn) fn <= reg_wdata_in[6:0];
      if (reg_wr_in && reg_addr_in == gpm_pkg::OFS_POL) pol <= reg_wdata_in[3:0];
      // Only function writes move pin roles, so only they restart the count
      age <= wr_fn ? 4'h0 : age + {3'h0, age != 4'hf};
    end
  end
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!nrst_in);
  a_clk4_shape: assert property (disable iff (!nrst_in || !calm)
    !fn[2] && $rose(gpio_out[1]) |=> gpio_out[1] ##1 (!gpio_out[1]) [*2] ##1 gpio_out[1])
    else $error("clock/4 shape wrong");
  a_clk6_shape: assert property (disable iff (!nrst_in || !calm)
    !fn[3] && $rose(gpio_out[2]) |=> gpio_out[2] [*2] ##1 (!gpio_out[2]) [*3] ##1 gpio_out[2])
    else $error("clock/6 shape wrong");
  a_upper_idle: assert property (calm && !fn[6] |->
    &gpio_oe_n_out[15:9] && pci_side_in_out == 7'h00) else $error("upper pins active");
  a_default_roles: assert property (calm |->
    (fn[1:0] != 2'b00 || gpio_oe_n_out[0]) && (fn[4] || gpio_oe_n_out[3]) &&
    (fn[5] || gpio_oe_n_out[8]) && (fn[2] || !gpio_oe_n_out[1]) &&
    (fn[3] || !gpio_oe_n_out[2])) else $error("default pin role wrong");
  a_polarity_xor: assert property (ext_irq_out == (gpio_in[7:4] ^ pol))
    else $error("polarity wrong");
  a_mode_frozen: assert property ($past(nrst_in) |-> $stable(pci_mode_out))
    else $error("mode moved");
  a_host_route: assert property (!pci_mode_out |->
    host_irq_out == host_irq_in &&
    host_ctl_out == (host_ctl_pin_in & {2'b11, host_port_narrow_out, 1'b1}))
    else $error("host routing wrong");
  a_pci_quiet: assert property (pci_mode_out |-> host_ctl_out == 4'h0)
    else $error("host controls leak in PCI mode");
  a_narrow_upper: assert property (host_port_narrow_out |-> &host_data_oe_n_out[31:16])
    else $error("upper data driven");
endmodule
bind gpm_pin_mux gpm_pin_mux_properties #(.GPIO_W(GPIO_W)) chk (.clk_in(clk_in),
  .nrst_in(nrst_in), .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
  .gpio_in(gpio_in), .gpio_out(gpio_out), .gpio_oe_n_out(gpio_oe_n_out), .ext_irq_out(ext_irq_out),
  .pci_side_in_out(pci_side_in_out), .host_irq_in(host_irq_in), .host_irq_out(host_irq_out),
  .host_ctl_pin_in(host_ctl_pin_in), .host_ctl_out(host_ctl_out), .pci_mode_out(pci_mode_out),
  .host_port_narrow_out(host_port_narrow_out), .host_data_oe_n_out(host_data_oe_n_out));
`default_nettype wire

// *** tb/testbench.sv ***
// Self-checking bench: straps, defaults, clocks, routing, interrupts.
// Assumes the host model and the bound checker.
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_in, nrst_in, wr_s, rd_s, irq, pci_s, s2_s, s2clk, gpint, pia, pci_request_out, cb, cb_n, hi, hio;
  logic hio_n, fo, fo_n, drv, narrow, wide, pmode, wide_s, pm, wm, p1, p2;
  logic [3:0] addr, ext, ctl, ctl_pin, hctl, pctl;
  logic [6:0] pside;
  logic [15:0] gin, gout, goe_n;
  logic [31:0] wdata, rdata, hd_pin, hd_o, hd_out, hd_oe_n, rnd, m;
  int errors, n_checks, r1, r2;
  initial begin
    clk_in = 1'b0;
    forever #2 clk_in = ~clk_in;
  end
  gpm_pin_mux #(.GPIO_W(16)) DUT (.clk_in(clk_in), .nrst_in(nrst_in), .reg_addr_in(addr),
    .reg_wdata_in(wdata), .reg_wr_in(wr_s), .reg_rd_in(rd_s), .reg_rdata_out(rdata), .irq_out(irq),
    .pci_enable_strap_in(pci_s), .serial2_enable_strap_in(s2_s), .gpio_in(gin), .gpio_out(gout),
    .gpio_oe_n_out(goe_n), .serial2_ext_clock_in_out(s2clk), .gpio_interrupt_out(gpint),
    .ext_irq_out(ext), .pci_side_in_out(pside), .pci_interrupt_a_in(pia), .pci_request_in(pci_request_out),
    .pci_cbe3_o_in(cb), .pci_cbe3_oe_n_in(cb_n), .host_irq_in(hi), .host_irq_out(hio),
    .host_irq_oe_n_out(hio_n), .pci_frame_o_in(fo), .pci_frame_oe_n_in(fo_n),
    .host_ctl_pin_in(ctl_pin), .host_ctl_out(hctl), .pci_ctl_out(pctl), .host_data_pin_in(hd_pin),
    .host_data_o_in(hd_o), .host_data_drive_in(drv), .host_data_out(hd_out),
    .host_data_oe_n_out(hd_oe_n), .host_port_narrow_out(narrow), .host_port_wide_out(wide),
    .pci_mode_out(pmode));
  gpm_host_model host (.clk_in(clk_in), .nrst_in(nrst_in), .wide_in(wide_s), .drive_in(!drv),
    .ctl_in(ctl), .data_in(rnd), .ctl_pin_out(ctl_pin), .data_pin_out(hd_pin));
  // ==========================================================
  // Helpers
  // ==========================================================
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // Narrow bus leaves the upper half released even while driving
  function automatic logic [31:0] exp_oe(input logic d, input logic w);
    return !d ? 32'hffffffff : (w ? 32'h0 : 32'hffff0000);
  endfunction
  // PCI sideband inputs as the core should see them: rst, clk, gnt, idsel, cbe3
  function automatic logic [6:0] exp_side(input logic p, input logic [31:0] r);
    return p ? {r[27:26], r[24], r[21], r[22], 2'h0} : 7'h00;
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_in);
    addr <= a;
    wdata <= d;
    wr_s <= 1'b1;
    @(posedge clk_in);
    wr_s <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] exp);
    @(posedge clk_in);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk_in);
    rd_s <= 1'b0;
    #1 chk(rdata, exp);
  endtask
  task automatic do_reset(input logic pci, input logic w);
    @(posedge clk_in);
    nrst_in <= 1'b0;
    pci_s <= pci;
    wide_s <= w;
    s2_s <= !s2_s;
    pm = pci;
    wm = w;
    repeat (2) @(posedge clk_in);
    nrst_in <= 1'b1;
    #1 chk({pmode, wide, narrow}, {pci, w & !pci, !w & !pci});
  endtask
  // Random polarity, pin levels and host traffic, checked per mode
  task automatic mix(input int n);
    repeat (n) begin
      rnd = lfsr(rnd);
      wr(gpm_pkg::OFS_POL, {28'h0, rnd[3:0]});
      gin[7:4] <= rnd[7:4];
      gin[15:8] <= rnd[27:20];
      ctl <= rnd[11:8];
      {hi, fo, drv, pia, pci_request_out, cb, cb_n, fo_n} <= rnd[19:12];
      hd_o <= rnd;
      tick(2);
      m = exp_oe(rnd[17], wm || pm);
      chk(ext, {28'h0, rnd[7:4] ^ rnd[3:0]});
      chk({hctl, pctl}, pm ? {4'h0, rnd[11:8]} :
        {rnd[11:10], rnd[9] & !wm, rnd[8], 4'h0});
      chk({hio, hio_n}, pm ? {rnd[18], rnd[12]} : {rnd[19], 1'b0});
      chk(hd_oe_n, m);
      chk(hd_out | m, rnd | m);
      chk({s2clk, pside}, {rnd[20], exp_side(pm, rnd)});
      if (pm) chk({goe_n[15:9], gout[13:10]},
        {2'h3, !rnd[16], 2'h2, rnd[13], 3'h4, rnd[15:14]});
    end
  endtask
  task automatic summarize();
    if (errors == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // ==========================================================
  // Main sequence
  // ==========================================================
  initial begin
    {nrst_in, wr_s, rd_s, pci_s, s2_s, wide_s, hi, fo, fo_n, pia, pci_request_out, cb, cb_n, drv} = '0;
    {addr, ctl, gin, wdata, hd_o, errors, n_checks} = '0;
    rnd = 32'hb68053d2;
    do_reset(1'b0, 1'b0);
    rd(gpm_pkg::OFS_FUNC, 32'h0);
    rd(gpm_pkg::OFS_MODE, {29'h0, 1'b0, s2_s, 1'b0});
    rd(4'hf, 32'h0);
    // Count edges of both divided clocks over 24 cycles
    {p1, p2, r1, r2} = {gout[1], gout[2], 64'h0};
    repeat (24) begin
      tick(1);
      r1 += int'(gout[1] !== p1);
      r2 += int'(gout[2] !== p2);
      {p1, p2} = {gout[1], gout[2]};
    end
    chk(r1, 12);
    chk(r2, 8);
    mix(12);
    @(posedge clk_in);
    gin[7:4] <= 4'h0;
    wr(gpm_pkg::OFS_POL, 32'h0);
    wr(gpm_pkg::OFS_MASK, 32'h0);
    wr(gpm_pkg::OFS_STAT, 32'h1f);
    gin[4] <= 1'b1;
    tick(3);
    chk(irq, 1'b0);
    rd(gpm_pkg::OFS_STAT, 32'h1);
    wr(gpm_pkg::OFS_MASK, 32'h1);
    #1 chk(irq, 1'b1);
    // Pin 0 carries the interrupt while its function bit is set
    wr(gpm_pkg::OFS_FUNC, 32'h2);
    tick(2);
    chk({gpint, gout[0], goe_n[0]}, 3'b110);
    wr(gpm_pkg::OFS_FUNC, 32'h0);
    wr(gpm_pkg::OFS_STAT, 32'h1);
    #1 chk(irq, 1'b0);
    rd(gpm_pkg::OFS_STAT, 32'h0);
    // Falling edge once the polarity bit is set
    wr(gpm_pkg::OFS_POL, 32'h1);
    gin[4] <= 1'b0;
    tick(2);
    rd(gpm_pkg::OFS_STAT, 32'h1);
    rd(gpm_pkg::OFS_IN, {16'h0, gin});
    wr(gpm_pkg::OFS_DIR, 32'hffff);
    wr(gpm_pkg::OFS_OUT, rnd);
    tick(2);
    chk(goe_n & 16'hff09, 16'hff09);
    wr(gpm_pkg::OFS_FUNC, 32'h7d);
    tick(2);
    chk({goe_n & 16'hff0f, gout & 16'hff0f}, {16'h0, rnd[15:0] & 16'hff0f});
    do_reset(1'b1, 1'b1);
    rd(gpm_pkg::OFS_MODE, {29'h0, 1'b1, s2_s, 1'b1});
    @(posedge clk_in);
    pci_s <= 1'b0;
    tick(3);
    chk(pmode, 1'b1);
    // Enable the upper pins so the PCI sideband routing is exercised
    wr(gpm_pkg::OFS_FUNC, 32'h40);
    mix(12);
    summarize();
  end
  initial begin
    #40000;
    errors++;
    summarize();
  end
endmodule
`default_nettype wire
